/* design/ecg_egress_cell_grant_tracker.sv */
// egress cell receiver with output-queue permit tracking
`timescale 1ns/1ps
`default_nettype none

// How it works
// - drop idle cells, forward data cells only
// - discard cells failing header parity
// - extract blade permits, present to ingress
// - hold fabric while data mover stalls
// - master congestion blocks all ingress traffic of its priority
// - multicast congestion blocks multicast only
// - never select port with zero permit
// - 16-blade: one priority per cell, 16 blades
// - idle cell priority realigns the tracker
// - 32-blade: six steps, two groups each
// - 32-blade idle restarts at step one
// - 64-blade: twelve steps, four groups each
// - 64-blade idle restarts at step one
// - external wrap takes permits from pins
// - wrap mode: only blades 0,1 permitted
// - wrap master grant is A AND B
// - single device uses grant A only
// - 32-bit word is 8 pins times 4
// - header type 00 idle, 11 data
// - even parity over three header bytes
// - 16-blade idle carries permit priority
// - sync cells dropped without permit update
module ecg_egress_cell_grant_tracker
    import ecg_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // classic wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [3:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // deserialised link words
    input  wire logic [WORD_W-1:0]     cell_word,
    input  wire logic                  cell_valid,
    input  wire logic                  cell_sop,
    output logic                       fabric_hold,
    // egress data mover
    output logic      [WORD_W-1:0]     dm_word,
    output logic                       dm_valid,
    input  wire logic                  dm_ready,
    // grant pins, one bit per priority; multicast permit is a single pin
    input  wire logic [NUM_PRIO-1:0]   master_grant_a,
    input  wire logic [NUM_PRIO-1:0]   master_grant_b,
    input  wire logic                  multicast_congestion_permit,
    // ingress scheduler side
    output logic [NUM_PRIO*MAX_BLADES-1:0] port_queue_permit,
    output logic      [NUM_PRIO-1:0]   master_ok,
    output logic                       mc_ok,
    input  wire logic [5:0]            sel_blade,
    input  wire logic [1:0]            sel_prio,
    input  wire logic                  sel_mc,
    output logic                       sel_allowed
);
    localparam int SYN_W = 2 * NUM_PRIO + 1;

    // pin synchronisers: a change counts once stages two and three agree
    logic [SYN_W-1:0] syn1_q, syn2_q, syn3_q, pins_q, pins_d;
    always_comb begin
        pins_d = pins_q;
        for (int i = 0; i < SYN_W; i++) begin
            if (syn2_q[i] == syn3_q[i]) begin
                pins_d[i] = syn3_q[i];
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            syn1_q <= '0;
            syn2_q <= '0;
            syn3_q <= '0;
            pins_q <= '0;
        end else begin
            syn1_q <= {multicast_congestion_permit, master_grant_b,
                       master_grant_a};
            syn2_q <= syn1_q;
            syn3_q <= syn2_q;
            pins_q <= pins_d;
        end
    end
    logic [NUM_PRIO-1:0] ga, gb;
    assign ga = pins_q[NUM_PRIO-1:0];
    assign gb = pins_q[2*NUM_PRIO-1:NUM_PRIO];

    // configuration
    logic [31:0] cfg_q, cfg_d;
    logic        ext_wrap, own_blade, single_dev;
    ecg_mode_t   mode;
    assign ext_wrap   = cfg_q[CFG_EXT_WRAP];
    assign own_blade  = cfg_q[CFG_OWN_BLADE];
    assign single_dev = cfg_q[CFG_SINGLE];
    assign mode       = ecg_mode_t'(cfg_q[CFG_MODE_LSB +: 2]);

    // cell pipeline: three-word delay so header is judged before output
    logic [WORD_W-1:0] s0_q, s1_q, s2_q, s0_d, s1_d, s2_d;
    logic [3:0]        idx_q, idx_d, cur_idx;
    logic              keep_q, keep_d;
    logic [7:0]        h0, h1, h2;
    logic              hdr_now, par_ok, is_idle, is_data, is_sync;
    logic [1:0]        ctype;

    assign cur_idx = cell_sop ? 4'h0 : idx_q;
    assign hdr_now = cell_valid && (cur_idx == HDR_LAST_IDX);
    assign h0      = s1_q[MASTER_LSB +: 8];
    assign h1      = s0_q[MASTER_LSB +: 8];
    assign h2      = cell_word[MASTER_LSB +: 8];
    assign ctype   = h0[HDR_TYPE_LSB +: 2];
    assign par_ok  = ~^{h0, h1, h2};
    assign is_idle = (ctype == CELL_IDLE);
    assign is_data = (ctype == CELL_DATA);
    assign is_sync = is_idle && h0 == SYNC_BYTE && h1 == SYNC_BYTE
                     && h2 == SYNC_BYTE;

    always_comb begin
        s0_d   = s0_q;
        s1_d   = s1_q;
        s2_d   = s2_q;
        idx_d  = idx_q;
        keep_d = keep_q;
        if (cell_valid) begin
            s0_d  = cell_word;
            s1_d  = s0_q;
            s2_d  = s1_q;
            idx_d = cur_idx + 4'h1;
            if (hdr_now) begin
                keep_d = par_ok && is_data;
            end
        end
    end

    // permit tracking from cell headers
    logic [NUM_PRIO-1:0][MAX_BLADES-1:0] permit_q, permit_d;
    logic [3:0] step_q, step_d, step_last;
    logic [1:0] gshift, seq_prio, idle_prio;
    logic [1:0] seq_grp;
    logic       hdr_good;

    always_comb begin
        case (mode)
            ECG_MODE_32: gshift = 2'h1;
            ECG_MODE_64: gshift = 2'h2;
            default:     gshift = 2'h0;
        endcase
    end
    assign step_last = 4'((NUM_PRIO << gshift) - 1);
    assign seq_prio  = 2'(step_q >> gshift);
    assign seq_grp   = 2'(step_q & 4'((1 << gshift) - 1));
    assign idle_prio = h0[HDR_PRIO_LSB +: 2];
    assign hdr_good  = hdr_now && par_ok && !ext_wrap;

    always_comb begin
        permit_d = permit_q;
        step_d   = step_q;
        if (hdr_good && is_data) begin
            permit_d[seq_prio][seq_grp*GROUP_BLADES +: GROUP_BLADES] =
                {h2, h1};
            step_d = (step_q >= step_last) ? 4'h0 : step_q + 4'h1;
        end else if (hdr_good && is_idle && !is_sync) begin
            if (mode == ECG_MODE_32 || mode == ECG_MODE_64) begin
                step_d = 4'h0;
            end else if (idle_prio < 2'(NUM_PRIO)) begin
                permit_d[idle_prio][GROUP_BLADES-1:0] = {h2, h1};
                step_d = (idle_prio == 2'(NUM_PRIO - 1)) ? 4'h0
                       : {2'h0, idle_prio} + 4'h1;
            end
        end
    end

    // external wrap: permits for blade 0, and blade 1 unless single device, straight from grant pins
    logic [NUM_PRIO*MAX_BLADES-1:0] permit_vec_d;
    logic [NUM_PRIO-1:0]            master_d;
    always_comb begin
        permit_vec_d = permit_q;
        master_d     = ga;
        if (ext_wrap) begin
            permit_vec_d = '0;
            for (int p = 0; p < NUM_PRIO; p++) begin
                if (single_dev) begin
                    permit_vec_d[p*MAX_BLADES] = ga[p];
                end else begin
                    permit_vec_d[p*MAX_BLADES]     = own_blade ? gb[p]
                                                               : ga[p];
                    permit_vec_d[p*MAX_BLADES + 1] = own_blade ? ga[p]
                                                               : gb[p];
                end
            end
            master_d = single_dev ? ga : (ga & gb);
        end
    end

    // wishbone slave, answers every access one cycle after the strobe
    logic        ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [15:0] badpar_q, badpar_d, drops_q, drops_d;
    logic        wb_go;
    assign wb_go = wb_cyc_i && wb_stb_i && !ack_q;

    always_comb begin
        cfg_d    = cfg_q;
        ack_d    = wb_go;
        rdat_d   = 32'h0000_0000;
        badpar_d = badpar_q;
        drops_d  = drops_q;
        if (wb_go) begin
            if (wb_adr_i == REG_CONFIG) begin
                rdat_d = cfg_q;
                if (wb_we_i) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wb_sel_i[b]) begin
                            cfg_d[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                        end
                    end
                end
            end else if (wb_adr_i == REG_STATUS) begin
                rdat_d[STS_STEP_LSB +: 4]          = step_q;
                rdat_d[STS_MASTER_LSB +: NUM_PRIO] = master_ok;
                rdat_d[STS_MC_BIT]                 = mc_ok;
                rdat_d[STS_HOLD_BIT]               = fabric_hold;
            end else if (wb_adr_i == REG_BADPAR) begin
                rdat_d[15:0] = badpar_q;
                if (wb_we_i) begin
                    badpar_d = 16'h0;
                end
            end else if (wb_adr_i == REG_DROPS) begin
                rdat_d[15:0] = drops_q;
                if (wb_we_i) begin
                    drops_d = 16'h0;
                end
            end
        end
        // counters saturate; an event in the clearing cycle still counts
        if (hdr_now && !par_ok && badpar_d != 16'hFFFF) begin
            badpar_d = badpar_d + 16'h1;
        end
        if (hdr_now && par_ok && !is_data && drops_d != 16'hFFFF) begin
            drops_d = drops_d + 16'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s0_q              <= '0;
            s1_q              <= '0;
            s2_q              <= '0;
            idx_q             <= 4'h0;
            keep_q            <= 1'b0;
            permit_q          <= '0;
            step_q            <= 4'h0;
            port_queue_permit <= '0;
            master_ok         <= '0;
            mc_ok             <= 1'b0;
            dm_word           <= '0;
            dm_valid          <= 1'b0;
            fabric_hold       <= 1'b0;
            cfg_q             <= CFG_RESET;
            ack_q             <= 1'b0;
            rdat_q            <= 32'h0000_0000;
            badpar_q          <= 16'h0;
            drops_q           <= 16'h0;
        end else begin
            s0_q              <= s0_d;
            s1_q              <= s1_d;
            s2_q              <= s2_d;
            idx_q             <= idx_d;
            keep_q            <= keep_d;
            permit_q          <= permit_d;
            step_q            <= step_d;
            port_queue_permit <= permit_vec_d;
            master_ok         <= master_d;
            mc_ok             <= pins_q[SYN_W-1];
            dm_word           <= s2_q;
            dm_valid          <= cell_valid && keep_q;
            fabric_hold       <= !dm_ready;
            cfg_q             <= cfg_d;
            ack_q             <= ack_d;
            rdat_q            <= rdat_d;
            badpar_q          <= badpar_d;
            drops_q           <= drops_d;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // admission check offered to the ingress selector
    always_comb begin
        sel_allowed = 1'b0;
        if (sel_prio < 2'(NUM_PRIO)) begin
            sel_allowed = port_queue_permit[sel_prio*MAX_BLADES + sel_blade]
                          && master_ok[sel_prio]
                          && (!sel_mc || mc_ok);
        end
    end

    property p_idle_drop;
        @(posedge clk) disable iff (!rst_b)
        hdr_now && !is_data |=> !keep_q;
    endproperty
    a_idle_drop: assert property (p_idle_drop)
        else $error("non-data cell kept");

    property p_bad_parity;
        @(posedge clk) disable iff (!rst_b)
        hdr_now && !par_ok && badpar_q != 16'hFFFF && !wb_go
        |=> !keep_q && badpar_q == $past(badpar_q) + 16'h1;
    endproperty
    a_bad_parity: assert property (p_bad_parity)
        else $error("bad parity cell not discarded");

    property p_data_permit;
        @(posedge clk) disable iff (!rst_b)
        hdr_good && is_data && mode == ECG_MODE_16
        |=> permit_q[$past(seq_prio)][15:0] == {$past(h2), $past(h1)};
    endproperty
    a_data_permit: assert property (p_data_permit)
        else $error("16-blade permits not recorded");

    property p_hold;
        @(posedge clk) disable iff (!rst_b)
        !dm_ready |=> fabric_hold;
    endproperty
    a_hold: assert property (p_hold)
        else $error("fabric not held on stall");

    property p_master_block;
        @(posedge clk) disable iff (!rst_b)
        sel_prio < 2'(NUM_PRIO) && !master_ok[sel_prio] |-> !sel_allowed;
    endproperty
    a_master_block: assert property (p_master_block)
        else $error("selection allowed under master congestion");

    property p_mc_block;
        @(posedge clk) disable iff (!rst_b)
        sel_mc && !mc_ok |-> !sel_allowed;
    endproperty
    a_mc_block: assert property (p_mc_block)
        else $error("multicast allowed under congestion");

    property p_permit_zero;
        @(posedge clk) disable iff (!rst_b)
        sel_prio < 2'(NUM_PRIO)
        && !port_queue_permit[sel_prio*MAX_BLADES + sel_blade]
        |-> !sel_allowed;
    endproperty
    a_permit_zero: assert property (p_permit_zero)
        else $error("port without permit selected");

    property p_realign;
        @(posedge clk) disable iff (!rst_b)
        hdr_good && is_idle && !is_sync && mode == ECG_MODE_16
        && idle_prio == 2'h1 |=> step_q == 4'h2;
    endproperty
    a_realign: assert property (p_realign)
        else $error("idle priority did not realign");

    property p_idle_restart;
        @(posedge clk) disable iff (!rst_b)
        hdr_good && is_idle && !is_sync && mode != ECG_MODE_16
        && mode == ECG_MODE_32 |=> step_q == 4'h0;
    endproperty
    a_idle_restart: assert property (p_idle_restart)
        else $error("idle did not restart sequence");

    property p_wrap_zero;
        @(posedge clk) disable iff (!rst_b)
        ext_wrap ##1 ext_wrap |-> port_queue_permit[MAX_BLADES-1:2] == '0
        && port_queue_permit[2*MAX_BLADES-1:MAX_BLADES+2] == '0
        && port_queue_permit[3*MAX_BLADES-1:2*MAX_BLADES+2] == '0;
    endproperty
    a_wrap_zero: assert property (p_wrap_zero)
        else $error("wrap mode reports permit above blade 1");

    property p_sync_hold;
        @(posedge clk) disable iff (!rst_b)
        hdr_now && is_sync |=> permit_q == $past(permit_q);
    endproperty
    a_sync_hold: assert property (p_sync_hold)
        else $error("sync cell changed permits");

    property p_reset_state;
        @(posedge clk) $rose(rst_b) |-> step_q == 4'h0 && permit_q == '0;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("tracker not cleared by reset");
endmodule // ecg_egress_cell_grant_tracker

`default_nettype wire

/* design/ecg_pkg.sv */
// constants and types for the egress cell and permit tracker
package ecg_pkg;
    // link and cell shape
    localparam int LINK_PINS       = 8;
    localparam int LINK_SER_FACTOR = 4;
    localparam int WORD_W          = LINK_PINS * LINK_SER_FACTOR;
    localparam int CELL_WORDS      = 16;
    localparam int NUM_PRIO        = 3;
    localparam int MAX_BLADES      = 64;
    localparam int GROUP_BLADES    = 16;
    // master byte lane of a link word
    localparam int MASTER_LSB      = 16;
    // qualifier header byte fields
    localparam int HDR_PARITY_BIT  = 6;
    localparam int HDR_TYPE_LSB    = 4;
    localparam int HDR_PRIO_LSB    = 0;
    localparam logic [1:0] CELL_IDLE = 2'h0;
    localparam logic [1:0] CELL_DATA = 2'h3;
    localparam logic [7:0] SYNC_BYTE = 8'hCC;
    // word index of the last header byte
    localparam logic [3:0] HDR_LAST_IDX = 4'h2;
    // blade modes
    typedef enum logic [1:0] {
        ECG_MODE_16 = 2'h0,
        ECG_MODE_32 = 2'h1,
        ECG_MODE_64 = 2'h2
    } ecg_mode_t;
    // register offsets (byte addresses)
    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_BADPAR = 4'h8;
    localparam logic [3:0] REG_DROPS  = 4'hC;
    // config fields
    localparam int CFG_MODE_LSB  = 0;
    localparam int CFG_OWN_BLADE = 4;
    localparam int CFG_SINGLE    = 5;
    localparam int CFG_EXT_WRAP  = 31;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    // status fields
    localparam int STS_STEP_LSB   = 0;
    localparam int STS_MASTER_LSB = 8;
    localparam int STS_MC_BIT     = 11;
    localparam int STS_HOLD_BIT   = 12;
endpackage

/* tb/ecg_fabric_model.sv */
// switch fabric model sending cells over the deserialised link
`timescale 1ns/1ps
`default_nettype none
module ecg_fabric_model
    import ecg_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              fabric_hold,
    output logic      [WORD_W-1:0] cell_word,
    output logic                   cell_valid,
    output logic                   cell_sop
);
    initial begin
        cell_word  = '0;
        cell_valid = 1'b0;
        cell_sop   = 1'b0;
    end

    // one 16-word cell; bad flips the header parity on purpose
    task automatic send_cell(input logic [7:0] h0, h1, h2, input logic bad);
        logic [7:0] m;
        logic [7:0] b;
        int         i;
        m = h0;
        m[HDR_PARITY_BIT] = ^{h0[7], h0[5:0], h1, h2} ^ bad;
        i = 0;
        while (i < CELL_WORDS) begin
            @(posedge clk);
            if (fabric_hold === 1'b1) begin
                cell_valid <= 1'b0;
                cell_sop   <= 1'b0;
                cell_word  <= ~cell_word;
            end else begin
                b = (i == 0) ? m : (i == 1) ? h1 : (i == 2) ? h2 : SYNC_BYTE;
                cell_valid <= 1'b1;
                cell_sop   <= (i == 0);
                cell_word  <= {8'(i), b, 16'h5AA5};
                i++;
            end
        end
        // released word lines must not look like the last word
        @(posedge clk);
        cell_valid <= 1'b0;
        cell_sop   <= 1'b0;
        cell_word  <= ~cell_word;
    endtask
endmodule // ecg_fabric_model
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the egress cell and permit tracker
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ecg_pkg::*;
;
    logic                clk, rst_b, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [3:0]          wb_adr, wb_sel;
    logic [31:0]         wb_wdat, wb_rdat, rd, cfg;
    logic [WORD_W-1:0]   cell_word, dm_word;
    logic                cell_valid, cell_sop, fabric_hold, dm_valid;
    logic                dm_ready, mc_pin, mc_ok, sel_mc, sel_allowed;
    logic [NUM_PRIO-1:0] grant_a, grant_b, master_ok;
    logic [191:0]        pq, exp_pq;
    logic [5:0]          sel_blade;
    logic [1:0]          sel_prio;
    logic [WORD_W-1:0]   fwd_q[$];
    int                  num_errors, total_checks, cycles;

    ecg_egress_cell_grant_tracker ecg_egress_cell_grant_tracker_inst (
        .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .cell_word(cell_word), .cell_valid(cell_valid),
        .cell_sop(cell_sop), .fabric_hold(fabric_hold),
        .dm_word(dm_word), .dm_valid(dm_valid), .dm_ready(dm_ready),
        .master_grant_a(grant_a), .master_grant_b(grant_b),
        .multicast_congestion_permit(mc_pin), .port_queue_permit(pq),
        .master_ok(master_ok), .mc_ok(mc_ok), .sel_blade(sel_blade),
        .sel_prio(sel_prio), .sel_mc(sel_mc), .sel_allowed(sel_allowed));

    ecg_fabric_model ecg_fabric_model_inst (
        .clk(clk), .fabric_hold(fabric_hold), .cell_word(cell_word),
        .cell_valid(cell_valid), .cell_sop(cell_sop));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (dm_valid === 1'b1) fwd_q.push_back(dm_word);
    end

    // ceiling is more than ten times the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            $display("[FAIL] %0t timeout", $time);
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [191:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_sel  <= 4'hF;
        wb_adr  <= a;
        wb_wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (wb_ack !== 1'b1) chk(1'b0, 1'b1);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic put(input int p, g, input logic [7:0] h1, h2);
        exp_pq[p*64+g*16 +: 16] = {h2, h1};
        ecg_fabric_model_inst.send_cell(8'h30, h1, h2, 1'b0);
        // last forwarded word is pushed one edge later; compare off-edge
        repeat (2) @(negedge clk);
    endtask

    task automatic idle(input logic [7:0] h0, h1, h2);
        ecg_fabric_model_inst.send_cell(h0, h1, h2, 1'b0);
        repeat (2) @(negedge clk);
    endtask

    task automatic sel_chk(input logic [5:0] b, input logic [1:0] p,
                           input logic m, e);
        @(posedge clk);
        sel_blade <= b;
        sel_prio  <= p;
        sel_mc    <= m;
        @(negedge clk);
        chk(sel_allowed, e);
    endtask

    // pins go through synchronisers, so give them time to land
    task automatic pins(input logic [2:0] a, b, input logic m);
        @(posedge clk);
        grant_a <= a;
        grant_b <= b;
        mc_pin  <= m;
        repeat (8) @(posedge clk);
    endtask

    initial begin
        {rst_b, wb_cyc, wb_stb, wb_we, sel_mc} = '0;
        {wb_adr, wb_wdat, sel_blade, sel_prio} = '0;
        wb_sel = 4'hF;
        dm_ready = 1'b1;
        mc_pin = 1'b1;
        grant_a = 3'h7;
        grant_b = 3'h7;
        exp_pq = '0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        chk(pq, exp_pq);
        rdchk(REG_STATUS, 32'h0000_0F00);
        wb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
        rdchk(REG_STATUS, 32'h0000_0F00);
        rdchk(4'h2, 32'h0);
        $display("test reset done");

        for (int p = 0; p < 3; p++) begin
            put(p, 0, 8'h35 + 8'(p), 8'hC1 + 8'(p));
            chk(pq, exp_pq);
            if (p == 1) chk(fwd_q.size(), 29);
        end
        chk(fwd_q[1], {8'h01, 8'h35, 16'h5AA5});
        chk(fwd_q[15], {8'h0F, SYNC_BYTE, 16'h5AA5});
        put(0, 0, 8'h5A, 8'h00);
        chk(pq, exp_pq);
        sel_chk(6'd0, 2'd0, 1'b0, 1'b0);
        sel_chk(6'd1, 2'd0, 1'b0, 1'b1);
        $display("test 16-blade done");

        fwd_q.delete();
        exp_pq[64 +: 16] = 16'hF00F;
        idle(8'h01, 8'h0F, 8'hF0);
        chk(pq, exp_pq);
        put(2, 0, 8'h77, 8'h88);
        chk(pq, exp_pq);
        chk(fwd_q.size(), 16);
        fwd_q.delete();
        ecg_fabric_model_inst.send_cell(8'h30, 8'hFF, 8'hFF, 1'b1);
        chk(pq, exp_pq);
        rdchk(REG_BADPAR, 32'h1);
        idle(SYNC_BYTE, SYNC_BYTE, SYNC_BYTE);
        chk(pq, exp_pq);
        rdchk(REG_DROPS, 32'h2);
        chk(fwd_q.size(), 3);
        wb(1'b1, REG_BADPAR, 32'h0);
        rdchk(REG_BADPAR, 32'h0);
        $display("test drops done");

        wb(1'b1, REG_CONFIG, 32'h1);
        put(0, 0, 8'h11, 8'h22);
        idle(8'h00, SYNC_BYTE, SYNC_BYTE);
        put(0, 0, 8'h33, 8'h44);
        put(0, 1, 8'h55, 8'h66);
        chk(pq, exp_pq);
        rdchk(REG_STATUS, 32'h0000_0F02);
        wb(1'b1, REG_CONFIG, 32'h2);
        put(0, 2, 8'h99, 8'h99);
        idle(8'h00, SYNC_BYTE, SYNC_BYTE);
        for (int g = 0; g < 4; g++) put(0, g, 8'hFF, 8'hF0 + 8'(g));
        put(1, 0, 8'hFF, 8'hFF);
        chk(pq, exp_pq);
        rdchk(REG_STATUS, 32'h0000_0F05);
        $display("test 32/64-blade done");

        pins(3'b110, 3'b011, 1'b1);
        chk(master_ok, 3'b110);
        sel_chk(6'd0, 2'd0, 1'b0, 1'b0);
        sel_chk(6'd0, 2'd1, 1'b0, 1'b1);
        pins(3'b111, 3'b000, 1'b0);
        chk(mc_ok, 1'b0);
        sel_chk(6'd0, 2'd1, 1'b1, 1'b0);
        sel_chk(6'd0, 2'd1, 1'b0, 1'b1);
        $display("test congestion done");

        pins(3'b101, 3'b011, 1'b1);
        for (int k = 0; k < 3; k++) begin
            cfg = 32'h0;
            cfg[CFG_EXT_WRAP] = 1'b1;
            cfg[CFG_OWN_BLADE] = (k == 1);
            cfg[CFG_SINGLE] = (k == 2);
            wb(1'b1, REG_CONFIG, cfg);
            repeat (8) @(posedge clk);
            exp_pq = '0;
            for (int p = 0; p < 3; p++) begin
                exp_pq[p*64] = (k == 1) ? grant_b[p] : grant_a[p];
                exp_pq[p*64+1] = (k == 0) ? grant_b[p] :
                                 (k == 1) ? grant_a[p] : 1'b0;
            end
            chk(pq, exp_pq);
            chk(master_ok, (k == 2) ? 3'b101 : 3'b001);
        end
        $display("test wrap done");

        @(posedge clk);
        dm_ready <= 1'b0;
        repeat (2) @(posedge clk);
        chk(fabric_hold, 1'b1);
        dm_ready <= 1'b1;
        repeat (2) @(posedge clk);
        chk(fabric_hold, 1'b0);
        $display("test hold done");
        conclude();
    end
endmodule // testbench
`default_nettype wire
